// ===== dcao_pkg.sv
/*
 * Shared constants and carriers for the operand ALU core: register map,
 * reset values, operand register choices, opcodes, branch conditions.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package dcao_pkg;

	// Register byte offsets
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_FILE = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_PC = 8'h0C;
	localparam logic [7:0] ADR_DSPCFG = 8'h10;
	localparam logic [7:0] ADR_ACCA_LO = 8'h14;
	localparam logic [7:0] ADR_ACCA_HI = 8'h18;
	localparam logic [7:0] ADR_ACCB_LO = 8'h1C;
	localparam logic [7:0] ADR_ACCB_HI = 8'h20;
	localparam logic [1:0] ADR_WBANK = 2'h1;

	// Working register roles
	localparam int NUM_DEFAULT_WORK_REG = 16;
	localparam logic [3:0] DEFAULT_WORK_REG = 4'h0;
	localparam logic [3:0] SQR_BASE = 4'h4;
	localparam logic [3:0] PF_DEST_BASE = 4'h4;
	localparam logic [3:0] X_PTR_LO = 4'h8;
	localparam logic [3:0] X_PTR_HI = 4'h9;
	localparam logic [3:0] Y_PTR_LO = 4'hA;
	localparam logic [3:0] Y_PTR_HI = 4'hB;
	localparam logic [3:0] PF_INDEX_REG = 4'hC;

	// Prefetch mode: bit 3 picks pointer, kind 7 is none (low) or indexed (high)
	localparam logic [2:0] PF_KIND_SPECIAL = 3'h7;
	localparam logic [2:0] PF_KIND_MINUS = 3'h3;

	// Multiplier pairs as offsets from W4, six legal codes
	localparam logic [2:0] PAIR_LAST = 3'h5;
	localparam logic [1:0] PAIR_M [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
	localparam logic [1:0] PAIR_N [6] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h3};

	// Literal limits and reset values
	localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
	localparam logic [15:0] DEFAULT_WORK_REG_RST = 16'h0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
	localparam logic [39:0] ACC_MAX = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] ACC_MIN = 40'h80_0000_0000;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_ADD,
		OP_ADD_WITH_CARRY,
		OP_ARITH_SHIFT_RIGHT,
		OP_ARITH_SHIFT_BY_REG,
		OP_ARITH_SHIFT_BY_LIT,
		OP_BIT_CLEAR,
		OP_RELATIVE_BRANCH,
		OP_ACC_ADD,
		OP_ACC_ADD_SHIFTED,
		OP_MULTIPLY,
		OP_SQUARE
	} dcao_op_t;

	typedef enum logic [3:0] {
		COND_CARRY,
		COND_SIGNED_GE,
		COND_UNSIGNED_GE,
		COND_SIGNED_GT,
		COND_UNSIGNED_GT,
		COND_SIGNED_LE,
		COND_UNSIGNED_LE,
		COND_SIGNED_LT,
		COND_NEGATIVE,
		COND_NOT_CARRY,
		COND_NOT_NEGATIVE,
		COND_OVERFLOW,
		COND_ZERO,
		COND_NOT_ZERO,
		COND_ACC_A_OVERFLOW,
		COND_ALWAYS
	} dcao_cond_t;

	typedef struct packed {
		logic spare;
		logic litForm;
		logic useFile;
		logic toDefault;
		logic byteMode;
		logic accSel;
		logic [9:0] tenBitLiteral;
		logic [3:0] wd;
		logic [3:0] ws;
		logic [3:0] wb;
		dcao_op_t op;
	} dcao_cmd_t;

	typedef struct packed {
		logic [1:0] yDest;
		logic [3:0] yMode;
		logic [1:0] xDest;
		logic [3:0] xMode;
		logic [2:0] mulPair;
	} dcao_cfg_t;

	localparam dcao_cfg_t CFG_RST = '{2'h0, 4'h7, 2'h0, 4'h7, 3'h0};

	typedef struct packed {
		logic accBSaturateFlag;
		logic accASaturateFlag;
		logic accBOverflowFlag;
		logic accAOverflowFlag;
		logic zeroFlag;
		logic overflowFlag;
		logic negativeFlag;
		logic digitCarryFlag;
		logic carryFlag;
	} dcao_flags_t;

	typedef struct packed {
		logic busy;
		logic rejected;
		dcao_flags_t flags;
	} dcao_status_t;

endpackage

// ===== dcao_prefetch_agu.sv
/*
 * Address unit for one DSP operand prefetch port (X or Y space).
 * Assumes the caller supplies the two pointer registers and W12 values.
 */
module dcao_prefetch_agu import dcao_pkg::*; #(
	parameter logic [3:0] PTR_LO = X_PTR_LO,
	parameter logic [3:0] PTR_HI = X_PTR_HI
) (
	input wire logic [3:0] mode,
	input wire logic [15:0] ptrLo,
	input wire logic [15:0] ptrHi,
	input wire logic [15:0] idxVal,
	output logic fetch,
	output logic update,
	output logic [3:0] ptrIdx,
	output logic [15:0] addr,
	output logic [15:0] ptrNew
);
	// Mode decode: plain, post +2/4/6, post -2/4/6, indexed or none
	wire logic [2:0] kind = mode[2:0];
	wire logic special = kind == PF_KIND_SPECIAL;
	wire logic minus = kind > PF_KIND_MINUS;
	wire logic [15:0] ptr = mode[3] ? ptrHi : ptrLo;
	wire logic [1:0] steps = minus ? 2'(kind - PF_KIND_MINUS) : kind[1:0];
	wire logic [15:0] delta = {13'h0000, steps, 1'b0};

	// Indexed form only exists on the high pointer
	assign fetch = ~(special & ~mode[3]);
	assign update = fetch & ~special & (kind != 3'h0);
	assign ptrIdx = mode[3] ? PTR_HI : PTR_LO;
	assign addr = special ? 16'(ptrHi + idxVal) : ptr;
	assign ptrNew = minus ? 16'(ptr - delta) : 16'(ptr + delta);
endmodule // dcao_prefetch_agu

// ===== dcao_core.sv
/*
 * Operand ALU core: 16 working registers, one file register, two 40-bit
 * accumulators, status flags, PC and a Wishbone slave that issues commands.
 * Assumes a classic Wishbone master and X/Y data answered in the same cycle.
 */
// Our own choices: the address map and the Wishbone register port.

module dcao_core import dcao_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	output logic xFetch,
	output logic [15:0] xAddr,
	input wire logic [15:0] xData,
	output logic yFetch,
	output logic [15:0] yAddr,
	input wire logic [15:0] yData
);
	logic [15:0] default_work_reg [NUM_DEFAULT_WORK_REG];
	logic [15:0] wNext [NUM_DEFAULT_WORK_REG];
	logic [15:0] fileReg, fileNext, pcReg, pcNext, aluRes;
	logic [39:0] accAReg, accANext, accBReg, accBNext;
	dcao_flags_t flagsReg, flagsNext, aluFlags;
	dcao_cfg_t cfgReg;
	logic busyReg, rejectedReg, ackReg, aluWrite, taken;
	logic [31:0] datReg, rdData;

	function automatic logic accOver(input logic [39:0] a);
		accOver = ~((&a[39:31]) | ~(|a[39:31]));
	endfunction

	// Bus decode; a write lands on the edge where ack is seen high
	wire logic req = cyc_i & stb_i;
	wire logic wrEn = req & we_i & ackReg;
	wire logic [31:0] byteMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	wire logic [31:0] wrData = dat_i & byteMask;
	wire logic hitW = adr_i[7:6] == ADR_WBANK;
	wire logic [3:0] wIdx = adr_i[5:2];
	wire logic [31:0] accALoWr = (accAReg[31:0] & ~byteMask) | wrData;
	wire logic [31:0] accBLoWr = (accBReg[31:0] & ~byteMask) | wrData;
	wire logic [15:0] lowWr = (16'(rdData) & ~byteMask[15:0]) | wrData[15:0];
	wire dcao_status_t status = '{busyReg, rejectedReg, flagsReg};
	assign ack_o = ackReg;
	assign dat_o = datReg;

	// Read mux; unmapped offsets answer zero
	assign rdData = hitW ? 32'(default_work_reg[wIdx]) :
		adr_i == ADR_FILE ? 32'(fileReg) :
		adr_i == ADR_STATUS ? 32'(status) :
		adr_i == ADR_PC ? 32'(pcReg) :
		adr_i == ADR_DSPCFG ? 32'(cfgReg) :
		adr_i == ADR_ACCA_LO ? accAReg[31:0] :
		adr_i == ADR_ACCA_HI ? 32'(accAReg[39:32]) :
		adr_i == ADR_ACCB_LO ? accBReg[31:0] :
		adr_i == ADR_ACCB_HI ? 32'(accBReg[39:32]) : 32'h0000_0000;

	// Command issue; refused while a taken branch burns its second cycle
	wire dcao_cmd_t cmd = dcao_cmd_t'(wrData);
	wire logic issue = wrEn & (adr_i == ADR_CMD) & ~busyReg;
	wire logic isAdd = (cmd.op == OP_ADD) | (cmd.op == OP_ADD_WITH_CARRY);
	wire logic isMul = (cmd.op == OP_MULTIPLY);
	wire logic pairBad = isMul & (cfgReg.mulPair > PAIR_LAST);
	wire logic litBad = isAdd & cmd.litForm & cmd.byteMode & (cmd.tenBitLiteral > BYTE_LIT_MAX);
	wire logic opBad = cmd.op > OP_SQUARE;
	wire logic rejected = pairBad | litBad | opBad;
	wire logic go = issue & ~rejected;

	// Operand routing: file forms pair f with W0, literal forms reuse Wd
	wire logic [15:0] opA = cmd.useFile ? fileReg : (cmd.litForm ? default_work_reg[cmd.wd] : default_work_reg[cmd.wb]);
	wire logic [15:0] opB = cmd.useFile ? default_work_reg[DEFAULT_WORK_REG] :
		(cmd.litForm ? {6'h00, cmd.tenBitLiteral} : default_work_reg[cmd.ws]);
	wire logic [15:0] shSrc = cmd.useFile ? fileReg : default_work_reg[cmd.ws];
	wire logic destIsFile = cmd.useFile & ~cmd.toDefault;
	wire logic [3:0] destIdx = cmd.useFile ? DEFAULT_WORK_REG :
		(cmd.op == OP_BIT_CLEAR ? cmd.ws : cmd.wd);
	wire logic [15:0] destOld = destIsFile ? fileReg : default_work_reg[destIdx];

	// Separate 4-, 8- and 16-bit adders give digit, byte and word carries
	wire logic cin = (cmd.op == OP_ADD_WITH_CARRY) & flagsReg.carryFlag;
	wire logic [4:0] sum4 = 5'(opA[3:0]) + 5'(opB[3:0]) + 5'(cin);
	wire logic [8:0] sum8 = 9'(opA[7:0]) + 9'(opB[7:0]) + 9'(cin);
	wire logic [16:0] sum17 = 17'(opA) + 17'(opB) + 17'(cin);
	wire logic aMsb = cmd.byteMode ? opA[7] : opA[15];
	wire logic bMsb = cmd.byteMode ? opB[7] : opB[15];
	wire logic rMsb = cmd.byteMode ? sum8[7] : sum17[15];
	wire logic [15:0] addRes = cmd.byteMode ? {destOld[15:8], sum8[7:0]} : sum17[15:0];
	wire logic addZero = cmd.byteMode ? (sum8[7:0] == 8'h00) : (sum17[15:0] == 16'h0000);
	wire logic [4:0] shCount = (cmd.op == OP_ARITH_SHIFT_BY_REG) ? {1'b0, default_work_reg[cmd.ws][3:0]} :
		cmd.tenBitLiteral[4:0];
	wire logic [15:0] multiRes = 16'($signed(default_work_reg[cmd.wb]) >>> shCount);
	wire logic [15:0] oneRes = {shSrc[15], shSrc[15:1]};

	// ALU result and integer flags per opcode
	always_comb begin
		aluRes = destOld;
		aluFlags = flagsReg;
		aluWrite = 1'b0;
		unique case (cmd.op)
			OP_ADD, OP_ADD_WITH_CARRY: begin
				aluWrite = 1'b1;
				aluRes = addRes;
				aluFlags.carryFlag = cmd.byteMode ? sum8[8] : sum17[16];
				aluFlags.digitCarryFlag = cmd.byteMode ? sum4[4] : sum8[8];
				aluFlags.negativeFlag = rMsb;
				aluFlags.overflowFlag = (aMsb == bMsb) & (rMsb != aMsb);
				// Carry chains keep zero sticky so multiword sums test whole
				aluFlags.zeroFlag = addZero & ((cmd.op == OP_ADD) | flagsReg.zeroFlag);
			end
			OP_ARITH_SHIFT_RIGHT: begin
				aluWrite = 1'b1;
				aluRes = oneRes;
				aluFlags.carryFlag = shSrc[0];
				aluFlags.negativeFlag = oneRes[15];
				aluFlags.overflowFlag = 1'b0;
				aluFlags.zeroFlag = oneRes == 16'h0000;
			end
			OP_ARITH_SHIFT_BY_REG, OP_ARITH_SHIFT_BY_LIT: begin
				aluWrite = 1'b1;
				aluRes = multiRes;
				aluFlags.negativeFlag = multiRes[15];
				aluFlags.zeroFlag = multiRes == 16'h0000;
			end
			OP_BIT_CLEAR: begin
				aluWrite = 1'b1;
				aluRes = shSrc & ~(16'h0001 << cmd.tenBitLiteral[3:0]);
			end
			default: begin
			end
		endcase
	end

	// Branch condition table
	always_comb begin
		unique case (dcao_cond_t'(cmd.wd))
			COND_CARRY: taken = flagsReg.carryFlag;
			COND_SIGNED_GE: taken = flagsReg.negativeFlag == flagsReg.overflowFlag;
			COND_UNSIGNED_GE: taken = flagsReg.carryFlag;
			COND_SIGNED_GT: taken = ~flagsReg.zeroFlag & (flagsReg.negativeFlag == flagsReg.overflowFlag);
			COND_UNSIGNED_GT: taken = flagsReg.carryFlag & ~flagsReg.zeroFlag;
			COND_SIGNED_LE: taken = flagsReg.zeroFlag | (flagsReg.negativeFlag != flagsReg.overflowFlag);
			COND_UNSIGNED_LE: taken = ~flagsReg.carryFlag | flagsReg.zeroFlag;
			COND_SIGNED_LT: taken = flagsReg.negativeFlag != flagsReg.overflowFlag;
			COND_NEGATIVE: taken = flagsReg.negativeFlag;
			COND_NOT_CARRY: taken = ~flagsReg.carryFlag;
			COND_NOT_NEGATIVE: taken = ~flagsReg.negativeFlag;
			COND_OVERFLOW: taken = flagsReg.overflowFlag;
			COND_ZERO: taken = flagsReg.zeroFlag;
			COND_NOT_ZERO: taken = ~flagsReg.zeroFlag;
			COND_ACC_A_OVERFLOW: taken = flagsReg.accAOverflowFlag;
			COND_ALWAYS: taken = 1'b1;
		endcase
	end
	wire logic isBranch = cmd.op == OP_RELATIVE_BRANCH;
	wire logic branchGo = go & isBranch & taken;
	wire logic [15:0] branchOfs = branchGo ? {{6{cmd.tenBitLiteral[9]}}, cmd.tenBitLiteral} : 16'h0000;

	// Accumulator adders saturate at 40 bits rather than wrap
	wire logic [39:0] accT = cmd.accSel ? accBReg : accAReg;
	wire logic [15:0] accWs = default_work_reg[cmd.ws];
	wire logic [3:0] slit = cmd.tenBitLiteral[3:0];
	wire logic [3:0] shAmt = slit[3] ? 4'(-slit) : slit;
	wire logic signed [39:0] shBase = {{8{accWs[15]}}, accWs, 16'h0000};
	wire logic [39:0] shifted = slit[3] ? 40'(shBase << shAmt) : 40'(shBase >>> shAmt);
	wire logic [39:0] addend = (cmd.op == OP_ACC_ADD) ? (cmd.accSel ? accAReg : accBReg) : shifted;
	wire logic [40:0] sum41 = {accT[39], accT} + {addend[39], addend};
	wire logic satHit = sum41[40] != sum41[39];
	wire logic [39:0] accSum = satHit ? (sum41[40] ? ACC_MIN : ACC_MAX) : sum41[39:0];
	wire logic accGo = go & ((cmd.op == OP_ACC_ADD) | (cmd.op == OP_ACC_ADD_SHIFTED));

	// Multiplier operands come only from W4..W7 by construction
	wire logic [2:0] pairIdx = pairBad ? 3'h0 : cfgReg.mulPair;
	wire logic isSqr = cmd.op == OP_SQUARE;
	wire logic [15:0] sqrOp = default_work_reg[SQR_BASE | {2'b00, cmd.wb[1:0]}];
	wire logic [15:0] mulA = isSqr ? sqrOp : default_work_reg[PF_DEST_BASE | {2'b00, PAIR_M[pairIdx]}];
	wire logic [15:0] mulB = isSqr ? sqrOp : default_work_reg[PF_DEST_BASE | {2'b00, PAIR_N[pairIdx]}];
	wire logic signed [31:0] prod = $signed(mulA) * $signed(mulB);
	wire logic [39:0] accProd = {{8{prod[31]}}, prod};
	wire logic mulGo = go & (isMul | isSqr);

	// Operand prefetch units
	wire logic xUpd, yUpd;
	wire logic [3:0] xPtrIdx, yPtrIdx;
	wire logic [15:0] xPtrNew, yPtrNew;
	dcao_prefetch_agu #(.PTR_LO(X_PTR_LO), .PTR_HI(X_PTR_HI)) xAgu (
		.mode(cfgReg.xMode), .ptrLo(default_work_reg[X_PTR_LO]), .ptrHi(default_work_reg[X_PTR_HI]),
		.idxVal(default_work_reg[PF_INDEX_REG]), .fetch(xFetch), .update(xUpd), .ptrIdx(xPtrIdx),
		.addr(xAddr), .ptrNew(xPtrNew));
	dcao_prefetch_agu #(.PTR_LO(Y_PTR_LO), .PTR_HI(Y_PTR_HI)) yAgu (
		.mode(cfgReg.yMode), .ptrLo(default_work_reg[Y_PTR_LO]), .ptrHi(default_work_reg[Y_PTR_HI]),
		.idxVal(default_work_reg[PF_INDEX_REG]), .fetch(yFetch), .update(yUpd), .ptrIdx(yPtrIdx),
		.addr(yAddr), .ptrNew(yPtrNew));
	wire logic [3:0] xDestIdx = PF_DEST_BASE | {2'b00, cfgReg.xDest};
	wire logic [3:0] yDestIdx = PF_DEST_BASE | {2'b00, cfgReg.yDest};

	// Next state of architectural storage; bus writes and commands never coincide
	always_comb begin
		wNext = default_work_reg;
		fileNext = fileReg;
		flagsNext = flagsReg;
		accANext = accAReg;
		accBNext = accBReg;
		if (wrEn & hitW) wNext[wIdx] = lowWr;
		if (wrEn & (adr_i == ADR_FILE)) fileNext = lowWr;
		if (wrEn & (adr_i == ADR_STATUS)) flagsNext = dcao_flags_t'(lowWr[8:0]);
		if (wrEn & (adr_i == ADR_ACCA_LO)) accANext[31:0] = accALoWr;
		if (wrEn & (adr_i == ADR_ACCA_HI)) accANext[39:32] = lowWr[7:0];
		if (wrEn & (adr_i == ADR_ACCB_LO)) accBNext[31:0] = accBLoWr;
		if (wrEn & (adr_i == ADR_ACCB_HI)) accBNext[39:32] = lowWr[7:0];
		if (go & aluWrite) begin
			if (destIsFile) fileNext = aluRes;
			else wNext[destIdx] = aluRes;
			flagsNext = aluFlags;
		end
		if (accGo | mulGo) begin
			if (cmd.accSel) accBNext = accGo ? accSum : accProd;
			else accANext = accGo ? accSum : accProd;
		end
		if (mulGo) begin
			if (xFetch) wNext[xDestIdx] = xData;
			if (yFetch) wNext[yDestIdx] = yData;
			if (xUpd) wNext[xPtrIdx] = xPtrNew;
			if (yUpd) wNext[yPtrIdx] = yPtrNew;
		end
		if (accGo) begin
			flagsNext.accAOverflowFlag = accOver(accANext);
			flagsNext.accBOverflowFlag = accOver(accBNext);
			flagsNext.accASaturateFlag = flagsReg.accASaturateFlag | (satHit & ~cmd.accSel);
			flagsNext.accBSaturateFlag = flagsReg.accBSaturateFlag | (satHit & cmd.accSel);
		end
	end

	// One word per command; a taken branch adds its offset
	assign pcNext = (wrEn & (adr_i == ADR_PC)) ? lowWr : (go ? 16'(pcReg + 16'h0001 + branchOfs) : pcReg);

	// Architectural registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_DEFAULT_WORK_REG; i++) default_work_reg[i] <= DEFAULT_WORK_REG_RST;
			fileReg <= DEFAULT_WORK_REG_RST;
			accAReg <= ACC_RST;
			accBReg <= ACC_RST;
			flagsReg <= '0;
			pcReg <= PC_RST;
		end else begin
			default_work_reg <= wNext;
			fileReg <= fileNext;
			accAReg <= accANext;
			accBReg <= accBNext;
			flagsReg <= flagsNext;
			pcReg <= pcNext;
		end
	end

	// Bus answer and sequencing state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ackReg <= 1'b0;
			datReg <= 32'h0000_0000;
			cfgReg <= CFG_RST;
			busyReg <= 1'b0;
			rejectedReg <= 1'b0;
		end else begin
			ackReg <= req & ~ackReg;
			datReg <= rdData;
			if (wrEn & (adr_i == ADR_DSPCFG)) cfgReg <= dcao_cfg_t'(lowWr[14:0]);
			busyReg <= branchGo;
			if (issue) rejectedReg <= rejected;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_default_reg;
		go & (cmd.op == OP_ADD) & cmd.useFile & cmd.toDefault & ~cmd.byteMode |=> default_work_reg[0] == $past(sum17[15:0]);
	endproperty
	a_default_reg: assert property (p_default_reg) else $error("default register not written");
	property p_sticky_zero;
		go & (cmd.op == OP_ADD_WITH_CARRY) & cmd.useFile & ~flagsReg.zeroFlag |=> !flagsReg.zeroFlag;
	endproperty
	a_sticky_zero: assert property (p_sticky_zero) else $error("zero flag not sticky");
	property p_lit_add;
		go & (cmd.op == OP_ADD_WITH_CARRY) & cmd.litForm & ~cmd.byteMode |=> default_work_reg[$past(cmd.wd)] ==
			$past(16'(default_work_reg[cmd.wd] + {6'h00, cmd.tenBitLiteral} + {15'h0000, flagsReg.carryFlag}));
	endproperty
	a_lit_add: assert property (p_lit_add) else $error("literal add result wrong");
	property p_pair_reject;
		issue & pairBad |=> $stable(accAReg) && $stable(accBReg) && rejectedReg;
	endproperty
	a_pair_reject: assert property (p_pair_reject) else $error("illegal pair executed");
	property p_square;
		go & isSqr |=> ($past(cmd.accSel) ? accBReg[39:31] : accAReg[39:31]) == 9'h000;
	endproperty
	a_square: assert property (p_square) else $error("square result negative");
	property p_acc_flags;
		accGo |=> $stable(flagsReg[4:0]);
	endproperty
	a_acc_flags: assert property (p_acc_flags) else $error("accumulator add touched integer flags");
	property p_shift_one;
		go & (cmd.op == OP_ARITH_SHIFT_RIGHT) & ~cmd.useFile |=>
			default_work_reg[$past(cmd.wd)][15] == $past(shSrc[15]) && flagsReg.carryFlag == $past(shSrc[0]);
	endproperty
	a_shift_one: assert property (p_shift_one) else $error("single shift lost sign");
	property p_shift_multi;
		go & ((cmd.op == OP_ARITH_SHIFT_BY_REG) | (cmd.op == OP_ARITH_SHIFT_BY_LIT)) |=>
			$stable(flagsReg.carryFlag) && $stable(flagsReg.overflowFlag) && $stable(flagsReg.digitCarryFlag);
	endproperty
	a_shift_multi: assert property (p_shift_multi) else $error("multi shift touched C or OV");
	property p_branch_taken;
		branchGo |=> busyReg ##1 !busyReg && $stable(flagsReg);
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("taken branch not two cycles");
	property p_branch_skip;
		go & isBranch & ~taken |=> !busyReg && $stable(flagsReg) && pcReg == $past(pcReg) + 16'h0001;
	endproperty
	a_branch_skip: assert property (p_branch_skip) else $error("untaken branch wrong");
	property p_signed_ge;
		go & isBranch & (cmd.wd == 4'(COND_SIGNED_GE)) |=>
			busyReg == ($past(flagsReg.negativeFlag) == $past(flagsReg.overflowFlag));
	endproperty
	a_signed_ge: assert property (p_signed_ge) else $error("signed compare wrong");
	property p_bit_clear;
		go & (cmd.op == OP_BIT_CLEAR) & ~cmd.useFile |=>
			default_work_reg[$past(cmd.ws)][$past(cmd.tenBitLiteral[3:0])] == 1'b0 && $stable(flagsReg);
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");
	property p_prefetch;
		mulGo & xFetch |=> default_work_reg[$past(xDestIdx)] == $past(xData);
	endproperty
	a_prefetch: assert property (p_prefetch) else $error("prefetch data not stored");

	c_branch: cover property (branchGo ##2 issue);
	c_carry_add: cover property (go & (cmd.op == OP_ADD_WITH_CARRY) & cmd.litForm & flagsReg.carryFlag);
	c_mac_fetch: cover property (mulGo & xFetch & yFetch & xUpd);
	c_saturate: cover property (accGo & satHit);
endmodule // dcao_core

// ===== dsp_core_operand_alu_ops_tb.sv
/* Self-checking bench for the operand ALU core, one task per scenario.
   Assumes X and Y memory answer with fixed words and a classic Wishbone slave. */
module dsp_core_operand_alu_ops_tb import dcao_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	logic clk = 1'b0, rstN = 1'b0, cycI = 1'b0, stbI = 1'b0, weI = 1'b0, ackO, xFetch, yFetch;
	logic [7:0] adrI = 8'h00;
	logic [3:0] selI = 4'h0;
	logic [31:0] datI = 32'h0000_0000, datO;
	logic [15:0] xData = 16'h0003, yData = 16'h0005, xAddr, yAddr;
	int errTotal = 0, samplesChecked = 0;
	always #5 clk = ~clk;
	dcao_core dut (.clk(clk), .rst_n(rstN), .cyc_i(cycI), .stb_i(stbI), .we_i(weI), .adr_i(adrI),
		.sel_i(selI), .dat_i(datI), .ack_o(ackO), .dat_o(datO), .xFetch(xFetch), .xAddr(xAddr),
		.xData(xData), .yFetch(yFetch), .yAddr(yAddr), .yData(yData));
	// Four-state compare, so an unknown never passes
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samplesChecked++;
		if (g !== e) begin
			errTotal++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Request held until ack is sampled; only the watchdog ends a wait on a dead slave
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		cycI <= 1'b1;
		stbI <= 1'b1;
		weI <= w;
		adrI <= a;
		selI <= 4'hF;
		datI <= d;
		@(posedge clk);
		while (ackO !== 1'b1) @(posedge clk);
		q = datO;
		cycI <= 1'b0;
		stbI <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, ZERO, q);
		chk(q, e);
	endtask
	function automatic logic [31:0] cmd(dcao_op_t o, logic [3:0] b, logic [3:0] s, logic [3:0] d, logic [9:0] l,
		logic [4:0] f);
		return {1'b0, f, l, d, s, b, o};
	endfunction
	function automatic logic [7:0] wa(int n);
		return 8'h40 + 8'(4 * n);
	endfunction
	// Reset values, all sixteen registers, unmapped hole
	task automatic tRegs();
		rd(ADR_STATUS, ZERO);
		rd(ADR_DSPCFG, 32'h0000_0E38);
		for (int n = 0; n < 16; n++) wr(wa(n), 32'h0000_1111 * n);
		for (int n = 0; n < 16; n++) rd(wa(n), 32'h0000_1111 * n);
		rd(8'h3C, ZERO);
	endtask
	// File add-with-carry to W0, then to the file; zero flag is only ever cleared
	task automatic tAddc();
		wr(ADR_FILE, 32'h0000_7FFF);
		wr(wa(0), ZERO);
		wr(ADR_STATUS, 32'h0000_0011);
		wr(ADR_CMD, cmd(OP_ADD_WITH_CARRY, 4'h0, 4'h0, 4'h0, 10'h000, 5'h0C));
		rd(wa(0), 32'h0000_8000);
		rd(ADR_FILE, 32'h0000_7FFF);
		rd(ADR_STATUS, 32'h0000_000E);
		wr(ADR_FILE, 32'h0000_FFFF);
		wr(wa(0), ZERO);
		wr(ADR_STATUS, 32'h0000_0001);
		wr(ADR_CMD, cmd(OP_ADD_WITH_CARRY, 4'h0, 4'h0, 4'h0, 10'h000, 5'h08));
		rd(ADR_FILE, ZERO);
		rd(ADR_STATUS, 32'h0000_0003);
		wr(ADR_FILE, 32'h0000_0100);
		wr(ADR_CMD, cmd(OP_ADD, 4'h0, 4'h0, 4'h0, 10'h000, 5'h0C));
		rd(wa(0), 32'h0000_0100);
		rd(ADR_STATUS, ZERO);
	endtask
	// Literal add with carry at the word-mode ceiling
	task automatic tLit();
		wr(wa(3), 32'h0000_0010);
		wr(ADR_STATUS, 32'h0000_0001);
		wr(ADR_CMD, cmd(OP_ADD_WITH_CARRY, 4'h0, 4'h0, 4'h3, 10'h3FF, 5'h10));
		rd(wa(3), 32'h0000_0410);
		rd(ADR_STATUS, 32'h0000_0002);
	endtask
	// Shifts keep the sign; multi-bit shifts and bit clear leave C and OV
	task automatic tShift();
		wr(wa(1), 32'h0000_8003);
		wr(ADR_STATUS, 32'h0000_001A);
		wr(ADR_CMD, cmd(OP_ARITH_SHIFT_RIGHT, 4'h0, 4'h1, 4'h2, 10'h000, 5'h00));
		rd(wa(2), 32'h0000_C001);
		rd(ADR_STATUS, 32'h0000_0007);
		wr(ADR_STATUS, 32'h0000_0019);
		wr(ADR_CMD, cmd(OP_ARITH_SHIFT_BY_LIT, 4'h1, 4'h0, 4'h5, 10'h004, 5'h00));
		rd(wa(5), 32'h0000_F800);
		wr(wa(6), 32'h0000_000F);
		wr(ADR_CMD, cmd(OP_ARITH_SHIFT_BY_REG, 4'h1, 4'h6, 4'h7, 10'h000, 5'h00));
		rd(wa(7), 32'h0000_FFFF);
		rd(ADR_STATUS, 32'h0000_000D);
		wr(ADR_CMD, cmd(OP_BIT_CLEAR, 4'h0, 4'h2, 4'h0, 10'h00F, 5'h00));
		rd(wa(2), 32'h0000_4001);
		rd(ADR_STATUS, 32'h0000_000D);
	endtask
	// Carry, signed GE and unsigned GE, each taken (even rows) and not taken; flags must survive
	task automatic tBranch();
		logic [31:0] p;
		logic [3:0] cnd [6] = '{COND_CARRY, COND_CARRY, COND_SIGNED_GE, COND_SIGNED_GE, COND_UNSIGNED_GE, COND_UNSIGNED_GE};
		logic [3:0] st [6] = '{4'h1, 4'h0, 4'hC, 4'h4, 4'h1, 4'h8};
		for (int i = 0; i < 6; i++) begin
			wr(ADR_STATUS, {28'h000_0000, st[i]});
			bus(1'b0, ADR_PC, ZERO, p);
			wr(ADR_CMD, cmd(OP_RELATIVE_BRANCH, 4'h0, 4'h0, cnd[i], 10'h003, 5'h00));
			rd(ADR_PC, p + ((i % 2 == 0) ? 32'h0000_0004 : 32'h0000_0001));
			rd(ADR_STATUS, {28'h000_0000, st[i]});
		end
	endtask
	// Pair W4*W6, X via W9 post+4 into W5, Y via W10 plain into W7
	task automatic tDsp();
		wr(wa(4), 32'h0000_0002);
		wr(wa(6), 32'h0000_0007);
		wr(wa(9), 32'h0000_1000);
		wr(wa(10), 32'h0000_2000);
		wr(wa(12), 32'h0000_0010);
		wr(ADR_DSPCFG, 32'h0000_60D1);
		chk({15'h0000, xFetch, xAddr}, 32'h0001_1000);
		chk({15'h0000, yFetch, yAddr}, 32'h0001_2000);
		wr(ADR_CMD, cmd(OP_MULTIPLY, 4'h0, 4'h0, 4'h0, 10'h000, 5'h00));
		rd(ADR_ACCA_LO, 32'h0000_000E);
		rd(wa(5), 32'h0000_0003);
		rd(wa(7), 32'h0000_0005);
		rd(wa(9), 32'h0000_1004);
		rd(wa(10), 32'h0000_2000);
		wr(ADR_CMD, cmd(OP_SQUARE, 4'h1, 4'h0, 4'h0, 10'h000, 5'h01));
		rd(ADR_ACCB_LO, 32'h0000_0009);
		wr(ADR_STATUS, 32'h0000_001F);
		wr(ADR_CMD, cmd(OP_ACC_ADD, 4'h0, 4'h0, 4'h0, 10'h000, 5'h00));
		rd(ADR_ACCA_LO, 32'h0000_0017);
		rd(ADR_STATUS, 32'h0000_001F);
		wr(ADR_ACCB_LO, 32'hFFFF_FFFF);
		wr(ADR_ACCB_HI, 32'h0000_007F);
		wr(ADR_CMD, cmd(OP_ACC_ADD_SHIFTED, 4'h0, 4'h6, 4'h0, 10'h000, 5'h01));
		rd(ADR_ACCB_LO, 32'hFFFF_FFFF);
		rd(ADR_ACCB_HI, 32'h0000_007F);
		rd(ADR_STATUS, 32'h0000_015F);
		wr(ADR_STATUS, 32'h0000_001F);
		wr(ADR_DSPCFG, 32'h0000_0E78);
		chk({15'h0000, xFetch, xAddr}, 32'h0001_1018);
		chk({31'h0000_0000, yFetch}, ZERO);
	endtask
	// Refused commands change nothing but the rejected bit; kept last as it may stick
	task automatic tReject();
		logic [31:0] p;
		bus(1'b0, ADR_PC, ZERO, p);
		wr(ADR_CMD, cmd(OP_ADD, 4'h0, 4'h0, 4'h3, 10'h100, 5'h12));
		rd(wa(3), 32'h0000_0410);
		rd(ADR_PC, p);
		wr(ADR_DSPCFG, 32'h0000_0E3E);
		wr(ADR_CMD, cmd(OP_MULTIPLY, 4'h0, 4'h0, 4'h0, 10'h000, 5'h00));
		rd(ADR_PC, p);
		rd(ADR_STATUS, 32'h0000_021F);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rstN <= 1'b1;
		@(posedge clk);
		tRegs();
		tAddc();
		tLit();
		tShift();
		tBranch();
		tDsp();
		tReject();
		give_verdict();
	end
	// Watchdog: the run needs well under a thousand cycles
	initial begin
		repeat (4000) @(posedge clk);
		errTotal++;
		give_verdict();
	end
endmodule // dsp_core_operand_alu_ops_tb
